// [inc/sprc_cfg.svh]
// constants for the serial unit with power, debug and reset control
`ifndef SPRC_CFG_SVH
`define SPRC_CFG_SVH
`define SPRC_DW 8
`define SPRC_BW 3
`define SPRC_PW 3
`define SPRC_BIT_LAST 3'h7
`define SPRC_BIT_FIRST 3'h0
`define SPRC_BIT_ONE 3'h1
`define SPRC_BRG_RST 8'h00
`define SPRC_BRG_ONE 8'h01
`define SPRC_WORD_RST 8'h00
`define SPRC_MSB 7
`define SPRC_FS_OUT 1'b0
`endif

// [inc/sprc_pkg.sv]
// types shared by the serial unit modules
package sprc_pkg;
  `include "sprc_cfg.svh"

  typedef logic [`SPRC_DW-1:0] sprc_word_type;
  typedef logic [`SPRC_PW-1:0] sprc_prio_type;

  typedef enum logic [0:0] {
    SPRC_IDLE = 1'b0,
    SPRC_SHIFT = 1'b1
  } sprc_state_type;

  typedef struct packed {
    sprc_state_type st;
    logic [`SPRC_DW-1:0] brg;
    logic sck;
    logic [`SPRC_BW-1:0] bitn;
    sprc_word_type sh;
    logic smp;
    sprc_word_type txb;
    logic txf;
    sprc_word_type rxb;
    logic rbf;
    logic evt;
    logic frz_w;
    logic frz_e;
    logic dbg_d;
    logic req;
    logic done_d;
    sprc_word_type slv_tx;
    logic fs;
  } sprc_main_type;

  typedef struct packed {
    logic [`SPRC_BW-1:0] bitn;
    sprc_word_type rxs;
    sprc_word_type txs;
    sprc_word_type rxw;
    logic done;
    logic ack;
  } sprc_slave_type;
endpackage

// [inc/sprc_link_if.sv]
// signals between the core and the slave shifter on the link clock
`timescale 1ns/1ps
interface sprc_link_if;
  logic [7:0] tx_word;
  logic tx_req;
  logic tx_ack;
  logic [7:0] rx_word;
  logic rx_done;
  logic sdi;
  logic sdo;
  logic ss_pin;
  logic slave_on;
  logic ss_use;
  modport core (output tx_word, tx_req, sdi, ss_pin, slave_on, ss_use, input tx_ack, rx_word, rx_done, sdo);
  modport shift (input tx_word, tx_req, sdi, ss_pin, slave_on, ss_use, output tx_ack, rx_word, rx_done, sdo);
endinterface

// [design/sprc_sync2.sv]
// two-stage level synchroniser
`timescale 1ns/1ps
module sprc_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sprc_sync_type;
  sprc_sync_type r_reg;
  sprc_sync_type r_next;

  always_comb begin
    r_next.s1 = i_d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_q = r_reg.s2;
endmodule

// [design/sprc_slave_shift.sv]
// slave shifter clocked by the external serial clock
`timescale 1ns/1ps
module sprc_slave_shift
  import sprc_pkg::*;
(
  input wire logic i_sck,
  input wire logic i_nrst,
  sprc_link_if.shift lk
);
  sprc_slave_type r_reg;
  sprc_slave_type r_next;
  logic req_s;
  logic active;
  logic take;

  // request read as a level: the link clock stands still between frames, so a
  // synchroniser here would hold the word back past the first bit; the core
  // toggles it only with the word settled, a toggle racing the first edge waits a frame
  assign req_s = lk.tx_req;

  // select is low-active; framed mode or unused select means always selected
  assign active = lk.slave_on & (!lk.ss_use | !lk.ss_pin);
  assign take = req_s ^ r_reg.ack;

  always_comb begin
    r_next = r_reg;
    if (active) begin
      r_next.rxs = {r_reg.rxs[`SPRC_MSB-1:0], lk.sdi};
      r_next.bitn = r_reg.bitn + `SPRC_BIT_ONE;
      if (r_reg.bitn == `SPRC_BIT_FIRST) begin
        // written word goes out even in debug
        r_next.txs = (take ? lk.tx_word : `SPRC_WORD_RST) << 1;
        if (take) begin
          r_next.ack = req_s;
        end
      end else begin
        r_next.txs = r_reg.txs << 1;
      end
      if (r_reg.bitn == `SPRC_BIT_LAST) begin
        r_next.rxw = {r_reg.rxs[`SPRC_MSB-1:0], lk.sdi};
        r_next.done = ~r_reg.done;
      end
    end else begin
      r_next.bitn = `SPRC_BIT_FIRST;
    end
  end

  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lk.sdo = (r_reg.bitn == `SPRC_BIT_FIRST) ? (take & lk.tx_word[`SPRC_MSB]) : r_reg.txs[`SPRC_MSB];
  assign lk.rx_word = r_reg.rxw;
  assign lk.rx_done = r_reg.done;
  assign lk.tx_ack = r_reg.ack;

  a_slave_word_done: assert property (@(posedge i_sck) disable iff (!i_nrst)
    (active && r_reg.bitn == `SPRC_BIT_LAST) |=> (r_reg.done != $past(r_reg.done)))
    else $error("slave word end did not toggle done");
endmodule

// [design/sprc_top.sv]
// serial unit core: master engine, buffers, power and debug handling, pins
//
// Summary of operation
// - master in sleep stops the bit-rate counter and clears it to reset count
// - master transfer under way at sleep is abandoned and never resumed
// - master in sleep starts nothing and accepts no new data
// - slave keeps shifting on the external clock during sleep, finishing transfers
// - completed slave word sets receive-full flag and the receive event flag in the same cycle
// - enabled receive event above cpu priority wakes the device from sleep
// - slave is not reset by sleep; register contents survive sleep entry and exit
// - master with idle stop set halts in idle like sleep, else runs on
// - slave keeps running in idle whatever idle stop holds
// - with debug freeze clear the unit runs normally during debug halt
// - master with freeze holds all state during halt and resumes exactly
// - slave with freeze keeps shifting but discards words completed during halt
// - buffer reads during debug leave every status bit unchanged
// - master with freeze stores debug writes and sends after debug ends
// - slave with freeze stores debug writes and sends at next external transfer
// - debug freeze bit readable and writable only in debug, else reads zero
// - new freeze value acts only from next debug entry; reads the captured one
// - asynchronous reset clears controls, status, buffers and bit-rate counter
// - enabled unit overrides pin directions for clock, data in and data out
// - select pin carries frame sync in framed mode, else optional select input
`timescale 1ns/1ps
module sprc_top
  import sprc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_enable,
  input wire logic i_master_role_sel,
  input wire logic i_idle_stop_sel,
  input wire logic i_data_out_disable,
  input wire logic i_select_pin_enable,
  input wire logic i_framed_mode_enable,
  input wire logic i_frame_sync_dir,
  input wire logic [7:0] i_baud_div,
  input wire logic i_sleep,
  input wire logic i_idle,
  input wire logic i_debug,
  input wire logic i_debug_freeze_wr,
  input wire logic i_debug_freeze_wdata,
  output logic o_debug_freeze,
  input wire logic i_buf_wr,
  input wire logic [7:0] i_buf_wdata,
  input wire logic i_buf_rd,
  output logic [7:0] o_buf_rdata,
  output logic o_rx_buf_full_flag,
  output logic o_rx_event_flag,
  input wire logic i_rx_event_clr,
  input wire logic i_rx_event_enable,
  input wire sprc_pkg::sprc_prio_type i_rx_event_prio,
  input wire sprc_pkg::sprc_prio_type i_cpu_prio,
  output logic o_wake,
  output logic o_tx_buf_full,
  output logic o_busy,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic i_select_pin,
  output logic o_select_pin,
  output logic o_select_pin_oe,
  output logic o_port_override
);
  sprc_main_type r_reg;
  sprc_main_type r_next;
  sprc_link_if lk();
  logic sdi_s;
  logic ack_s;
  logic done_s;
  logic is_master;
  logic is_slave;
  logic stop_m;
  logic frozen;
  logic m_done;
  logic s_cap;
  logic cap;
  sprc_word_type cap_word;

  // master input data crosses from the pin; ack and done are link-clock toggles
  sprc_sync2 #(.W(3)) u_sync (
    .i_clk(i_clk_sys),
    .i_nrst(i_nrst),
    .i_d({i_sdi, lk.tx_ack, lk.rx_done}),
    .o_q({sdi_s, ack_s, done_s})
  );

  sprc_slave_shift u_slave (
    .i_sck(i_sck),
    .i_nrst(i_nrst),
    .lk(lk.shift)
  );

  assign is_master = i_enable & i_master_role_sel;
  assign is_slave = i_enable & !i_master_role_sel;
  // idle stops master only when idle stop set
  assign stop_m = is_master & (i_sleep | (i_idle & i_idle_stop_sel));
  // freeze only acts while halted with captured bit set
  assign frozen = i_debug & r_reg.frz_e;
  // words finished during a frozen halt are dropped
  assign s_cap = is_slave & (done_s ^ r_reg.done_d) & !frozen;
  assign cap = m_done | s_cap;
  assign cap_word = m_done ? {r_reg.sh[`SPRC_MSB-1:0], r_reg.smp} : lk.rx_word;

  // frame sync is driven only when the unit owns the pin
  function automatic logic fs_drive(input logic fme, input logic dir);
    return fme & (dir == `SPRC_FS_OUT);
  endfunction

  // master word ends at the falling edge of its eighth bit
  assign m_done = is_master & !stop_m & !frozen & (r_reg.st == SPRC_SHIFT) & (r_reg.brg == i_baud_div)
    & r_reg.sck & (r_reg.bitn == `SPRC_BIT_LAST);

  always_comb begin
    r_next = r_reg;
    r_next.dbg_d = i_debug;
    r_next.done_d = done_s;
    // freeze setting captured on debug entry
    if (i_debug && !r_reg.dbg_d) begin
      r_next.frz_e = r_reg.frz_w;
    end
    // freeze bit written only in debug
    if (i_debug && i_debug_freeze_wr) begin
      r_next.frz_w = i_debug_freeze_wdata;
    end
    if (!is_master || stop_m) begin
      // bit-rate counter back to reset count
      r_next.st = SPRC_IDLE;
      r_next.brg = `SPRC_BRG_RST;
      r_next.sck = 1'b0;
      r_next.bitn = `SPRC_BIT_FIRST;
      r_next.fs = 1'b0;
    end else if (frozen) begin
      r_next.st = r_reg.st;
    end else begin
      case (r_reg.st)
        SPRC_IDLE: begin
          if (r_reg.txf) begin
            r_next.sh = r_reg.txb;
            r_next.txf = 1'b0;
            r_next.st = SPRC_SHIFT;
            r_next.brg = `SPRC_BRG_RST;
            // frame sync pulse over the first bit
            r_next.fs = fs_drive(i_framed_mode_enable, i_frame_sync_dir);
          end
        end
        SPRC_SHIFT: begin
          if (r_reg.brg == i_baud_div) begin
            r_next.brg = `SPRC_BRG_RST;
            r_next.sck = ~r_reg.sck;
            if (!r_reg.sck) begin
              r_next.smp = sdi_s;
            end else begin
              r_next.sh = {r_reg.sh[`SPRC_MSB-1:0], r_reg.smp};
              r_next.bitn = r_reg.bitn + `SPRC_BIT_ONE;
              r_next.fs = 1'b0;
              if (m_done) begin
                r_next.st = SPRC_IDLE;
              end
            end
          end else begin
            r_next.brg = r_reg.brg + `SPRC_BRG_ONE;
          end
        end
        default: begin
          r_next.st = SPRC_IDLE;
        end
      endcase
    end
    // slave word handed to the link domain once the previous one was taken
    if (is_slave && r_reg.txf && (r_reg.req == ack_s)) begin
      r_next.slv_tx = r_reg.txb;
      r_next.req = ~r_reg.req;
      r_next.txf = 1'b0;
    end
    // no new data accepted while master is stopped
    // debug writes are stored, start waits for freeze to lift
    if (i_buf_wr && !stop_m) begin
      r_next.txb = i_buf_wdata;
      r_next.txf = 1'b1;
    end
    // receive-full and event flag on completion
    if (cap) begin
      r_next.rxb = cap_word;
      r_next.rbf = 1'b1;
      r_next.evt = 1'b1;
    end
    // reads in debug leave status alone; a new word beats the clear
    if (i_buf_rd && !i_debug && !cap) begin
      r_next.rbf = 1'b0;
    end
    if (i_rx_event_clr && !cap) begin
      r_next.evt = 1'b0;
    end
  end

  // everything cleared by the asynchronous reset
  // nothing here reacts to sleep for the slave
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lk.tx_word = r_reg.slv_tx;
  assign lk.tx_req = r_reg.req;
  assign lk.sdi = i_sdi;
  assign lk.ss_pin = i_select_pin;
  assign lk.slave_on = is_slave;
  // select input used only outside framed mode
  assign lk.ss_use = i_select_pin_enable & !i_framed_mode_enable;

  assign o_debug_freeze = i_debug & r_reg.frz_e;
  assign o_buf_rdata = r_reg.rxb;
  assign o_rx_buf_full_flag = r_reg.rbf;
  assign o_rx_event_flag = r_reg.evt;
  // wake when enabled and above cpu priority
  assign o_wake = r_reg.evt & i_rx_event_enable & (i_rx_event_prio > i_cpu_prio);
  assign o_tx_buf_full = r_reg.txf;
  assign o_busy = (r_reg.st == SPRC_SHIFT);
  // pin directions follow the role once enabled
  assign o_port_override = i_enable;
  assign o_sck = r_reg.sck;
  assign o_sck_oe = is_master;
  assign o_sdo = is_master ? r_reg.sh[`SPRC_MSB] : lk.sdo;
  assign o_sdo_oe = i_enable & !i_data_out_disable;
  // select driven only as frame sync output, never as master select
  assign o_select_pin = r_reg.fs;
  assign o_select_pin_oe = i_enable & fs_drive(i_framed_mode_enable, i_frame_sync_dir);

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  a_stop_brg_reset: assert property (
    stop_m |=> (r_reg.brg == `SPRC_BRG_RST) && !r_reg.sck)
    else $error("bit-rate counter not reset while stopped");

  a_stop_aborts: assert property (
    (stop_m && o_busy) |=> !o_busy ##1 (!stop_m || !o_busy))
    else $error("master transfer survived a stop");

  a_stop_no_take: assert property (
    (stop_m && i_buf_wr && !r_reg.txf) |=> !r_reg.txf)
    else $error("write accepted while master stopped");

  a_slave_no_sleep: assert property (
    (is_slave && i_sleep && !i_buf_wr && !cap && !i_buf_rd && !i_rx_event_clr) |=> $stable(r_reg.rxb) && $stable(r_reg.rbf))
    else $error("slave state changed by sleep");

  a_idle_runs: assert property (
    (is_master && i_idle && !i_idle_stop_sel && !i_sleep && !frozen && o_busy && r_reg.brg != i_baud_div)
      |=> r_reg.brg == $past(r_reg.brg) + `SPRC_BRG_ONE)
    else $error("master stopped in idle without idle stop");

  a_cap_flags: assert property (
    cap |=> o_rx_buf_full_flag && o_rx_event_flag && (o_buf_rdata == $past(cap_word)))
    else $error("completion did not set receive flags");

  a_wake_cause: assert property (
    o_wake |-> o_rx_event_flag && i_rx_event_enable && (i_rx_event_prio > i_cpu_prio))
    else $error("wake without enabled higher priority event");

  a_freeze_hold: assert property (
    (is_master && frozen && !stop_m && !i_buf_wr && $stable(i_enable) && $stable(i_master_role_sel))
      |=> $stable(r_reg.sh) && $stable(r_reg.brg) && $stable(r_reg.bitn) && $stable(r_reg.sck))
    else $error("master state moved during freeze");

  a_freeze_discard: assert property (
    (is_slave && frozen && !i_buf_rd && !i_rx_event_clr) |=> $stable(r_reg.rbf) && $stable(r_reg.evt))
    else $error("slave word kept during freeze");

  a_debug_read_keep: assert property (
    (i_debug && i_buf_rd && o_rx_buf_full_flag) |=> o_rx_buf_full_flag)
    else $error("debug read cleared receive-full flag");

  a_tx_held_debug: assert property (
    (is_master && frozen && !o_busy) |=> !o_busy)
    else $error("transmit started during frozen debug");

  a_frz_zero_out: assert property (
    !i_debug |-> !o_debug_freeze)
    else $error("freeze bit visible outside debug");

  a_frz_entry: assert property (
    $rose(i_debug) |=> (r_reg.frz_e == $past(r_reg.frz_w)) ##1 (!i_debug || $stable(r_reg.frz_e)))
    else $error("freeze not captured at debug entry");

  a_pin_dirs: assert property (
    i_enable |-> (o_sck_oe == i_master_role_sel) && (o_sdo_oe == !i_data_out_disable))
    else $error("pin directions do not follow role");

  a_pins_released: assert property (
    !i_enable |-> !o_sck_oe && !o_sdo_oe && !o_select_pin_oe && !o_port_override)
    else $error("pins taken while unit disabled");

  a_debug_runs: assert property (
    (is_master && i_debug && !r_reg.frz_e && !stop_m && o_busy && r_reg.brg != i_baud_div)
      |=> r_reg.brg == $past(r_reg.brg) + `SPRC_BRG_ONE)
    else $error("master stalled in debug without freeze");

  a_idle_stop: assert property (
    (is_master && i_idle && i_idle_stop_sel) |=> !o_busy && !o_sck)
    else $error("master ran in idle with idle stop set");

  a_slave_idle_send: assert property (
    (is_slave && i_idle && i_idle_stop_sel && !i_buf_wr && r_reg.txf && (r_reg.req == ack_s)) |=> !o_tx_buf_full)
    else $error("slave hand-off stalled in idle");

  a_frozen_write_kept: assert property (
    (is_master && frozen && !stop_m && i_buf_wr) |=> o_tx_buf_full)
    else $error("debug write lost while frozen");

  a_slave_debug_send: assert property (
    (is_slave && frozen && !i_buf_wr && r_reg.txf && (r_reg.req == ack_s)) |=> !o_tx_buf_full)
    else $error("slave hand-off held during debug");

  a_fsync_first_bit: assert property (
    o_select_pin |-> o_busy && (r_reg.bitn == `SPRC_BIT_FIRST))
    else $error("frame sync outside the first bit");

  a_sleep_completes: assert property (
    (is_slave && i_sleep && s_cap) |=> o_rx_buf_full_flag)
    else $error("slave word lost in sleep");

  a_stop_bit_clear: assert property (
    (stop_m && o_busy) |=> (r_reg.bitn == `SPRC_BIT_FIRST) && !o_select_pin)
    else $error("bit count kept after stop");

  a_frz_write_gate: assert property (
    (!i_debug && i_debug_freeze_wr) |=> $stable(r_reg.frz_w))
    else $error("freeze bit written outside debug");

  a_reset_clear: assert property (disable iff (1'b0)
    !i_nrst |-> !o_busy && !o_tx_buf_full && !o_rx_buf_full_flag && !o_rx_event_flag
      && (o_buf_rdata == `SPRC_WORD_RST))
    else $error("state not cleared by reset");
endmodule

// [verif/sprc_ext_dev.sv]
// external serial device: slave to a master unit, or master to a slave unit
`timescale 1ns/1ps
module sprc_ext_dev (
  input wire logic i_sck,
  input wire logic i_sdo,
  input wire logic i_sel_n,
  input wire logic [7:0] i_tx,
  output logic o_sck,
  output logic o_sdi,
  output logic o_sel_n,
  output logic [7:0] o_rx
);
  logic [7:0] sh;

  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
    o_sel_n = 1'b1;
    o_rx = 8'h00;
    sh = 8'h00;
  end

  always @(negedge i_sel_n) begin
    sh = i_tx;
    o_sdi = sh[7];
  end

  always @(posedge i_sck) begin
    if (!i_sel_n) begin
      o_rx = {o_rx[6:0], i_sdo};
    end
  end

  always @(negedge i_sck) begin
    if (!i_sel_n) begin
      sh = {sh[6:0], 1'b0};
      o_sdi = sh[7];
    end
  end

  // released line shows no stale data
  always @(posedge i_sel_n) begin
    o_sdi = ~o_sdi;
  end

  // master side: clock stands low outside frames, bits change after the falling edge
  task automatic xfer();
    int i;
    o_sel_n = 1'b0;
    for (i = 7; i >= 0; i--) begin
      o_sdi = i_tx[i];
      #24;
      o_rx = {o_rx[6:0], i_sdo};
      o_sck = 1'b1;
      #24;
      o_sck = 1'b0;
    end
    o_sdi = ~o_sdi;
    #24;
    o_sel_n = 1'b1;
  endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the serial unit core
`timescale 1ns/1ps
module tb;
  import sprc_pkg::*;
  logic clk = 1'b0;
  logic rst_n, en, ms, ids, dod, spe, fme, fsd, slp, idl, dbg, fwr, fwd, wr, rd, eclr, een, psel_n;
  logic debug_freeze, rbf, evt, wake, txf, busy, sck, sck_oe, sdo, sdo_oe, ssp, ssp_oe, ovr, esck, esdi, esel_n;
  logic [7:0] div, wd, rdata, etx, erx, w, s, h;
  sprc_prio_type eprio, cprio;
  logic [7:0] exp_q[$];
  logic [31:0] rs = 32'h0000003E;
  int n_mismatch = 0;
  int checked = 0;
  int k;

  always #2.5 clk = ~clk;

  sprc_top DUT (.i_clk_sys(clk), .i_nrst(rst_n), .i_enable(en), .i_master_role_sel(ms), .i_idle_stop_sel(ids),
    .i_data_out_disable(dod), .i_select_pin_enable(spe), .i_framed_mode_enable(fme), .i_frame_sync_dir(fsd),
    .i_baud_div(div), .i_sleep(slp), .i_idle(idl), .i_debug(dbg), .i_debug_freeze_wr(fwr),
    .i_debug_freeze_wdata(fwd), .o_debug_freeze(debug_freeze), .i_buf_wr(wr), .i_buf_wdata(wd), .i_buf_rd(rd),
    .o_buf_rdata(rdata), .o_rx_buf_full_flag(rbf), .o_rx_event_flag(evt), .i_rx_event_clr(eclr),
    .i_rx_event_enable(een), .i_rx_event_prio(eprio), .i_cpu_prio(cprio), .o_wake(wake), .o_tx_buf_full(txf),
    .o_busy(busy), .i_sck(esck), .o_sck(sck), .o_sck_oe(sck_oe), .i_sdi(esdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .i_select_pin(esel_n), .o_select_pin(ssp), .o_select_pin_oe(ssp_oe), .o_port_override(ovr));
  sprc_ext_dev ext (.i_sck(sck), .i_sdo(sdo), .i_sel_n(psel_n), .i_tx(etx), .o_sck(esck), .o_sdi(esdi),
    .o_sel_n(esel_n), .o_rx(erx));

  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction

  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bwr(logic [7:0] v);
    @(posedge clk);
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read also clears the event, as a service routine would
  task automatic brd();
    @(posedge clk);
    rd <= 1'b1;
    eclr <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    eclr <= 1'b0;
  endtask

  task automatic wait_rbf();
    int t;
    for (t = 0; t < 3000 && rbf !== 1'b1; t++) begin
      @(posedge clk);
    end
    if (t == 3000) begin
      n_mismatch++;
      $display("Error rx full wait expected 1 seen %b", rbf);
      complete_run();
    end
  endtask

  task automatic mstart(logic [7:0] v);
    s = rnd();
    etx = s;
    exp_q.push_back(s);
    @(posedge clk);
    psel_n <= 1'b0;
    bwr(v);
  endtask

  task automatic mfinish(logic [7:0] v);
    wait_rbf();
    @(negedge clk);
    cmp("rx word", exp_q.pop_front(), rdata);
    cmp("far rx", v, erx);
    cmp("rx event", 8'h01, evt);
    @(posedge clk);
    psel_n <= 1'b1;
  endtask

  task automatic sxfer(logic [7:0] v);
    s = rnd();
    etx = s;
    bwr(v);
    cyc(4);
    #7;
    ext.xfer();
  endtask

  initial begin
    {rst_n, en, ids, dod, spe, fme, fsd, slp, idl, dbg, fwr, fwd, wr, rd, eclr, een, wd, eprio, cprio} = '0;
    ms = 1'b1;
    psel_n = 1'b1;
    div = 8'h03;
    etx = 8'h00;
    cyc(12);
    rst_n <= 1'b1;
    en <= 1'b1;
    @(negedge clk);
    cmp("reset flags", 8'h00, {busy, txf, evt, rbf, sck, debug_freeze});
    cmp("reset word", 8'h00, rdata);
    for (k = 0; k < 3; k++) begin
      w = rnd();
      mstart(w);
      mfinish(w);
      brd();
    end
    $display("test master transfer done");
    @(posedge clk);
    fme <= 1'b1;
    w = rnd();
    mstart(w);
    cyc(3);
    @(negedge clk);
    cmp("frame sync", 8'h01, ssp);
    mfinish(w);
    @(negedge clk);
    cmp("frame sync end", 8'h00, ssp);
    brd();
    @(posedge clk);
    fme <= 1'b0;
    $display("test framed master done");
    mstart(rnd());
    cyc(12);
    slp <= 1'b1;
    cyc(2);
    @(negedge clk);
    cmp("busy in sleep", 8'h00, busy);
    cmp("clock in sleep", 8'h00, sck);
    bwr(8'hA5);
    @(negedge clk);
    cmp("write in sleep", 8'h00, txf);
    @(posedge clk);
    slp <= 1'b0;
    void'(exp_q.pop_front());
    cyc(80);
    @(negedge clk);
    cmp("no resume", 8'h00, {busy, rbf, txf});
    @(posedge clk);
    psel_n <= 1'b1;
    $display("test master sleep done");
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      ids <= k[0];
      idl <= 1'b1;
      if (k == 0) begin
        w = rnd();
        mstart(w);
        mfinish(w);
        brd();
      end else begin
        bwr(8'h5A);
        cyc(20);
        @(negedge clk);
        cmp("idle stop", 8'h00, {txf, busy});
      end
      @(posedge clk);
      idl <= 1'b0;
    end
    $display("test master idle done");
    @(posedge clk);
    fwd <= 1'b1;
    fwr <= 1'b1;
    @(posedge clk);
    fwr <= 1'b0;
    dbg <= 1'b1;
    cyc(2);
    @(negedge clk);
    cmp("freeze first", 8'h00, debug_freeze);
    w = rnd();
    mstart(w);
    mfinish(w);
    @(posedge clk);
    fwr <= 1'b1;
    @(posedge clk);
    fwr <= 1'b0;
    @(negedge clk);
    cmp("freeze captured", 8'h00, debug_freeze);
    @(posedge clk);
    dbg <= 1'b0;
    brd();
    @(negedge clk);
    cmp("freeze outside", 8'h00, debug_freeze);
    @(posedge clk);
    dbg <= 1'b1;
    cyc(2);
    @(negedge clk);
    cmp("freeze reentry", 8'h01, debug_freeze);
    w = rnd();
    mstart(w);
    cyc(30);
    @(negedge clk);
    cmp("frozen write", 8'h02, {txf, busy});
    @(posedge clk);
    dbg <= 1'b0;
    mfinish(w);
    brd();
    w = rnd();
    mstart(w);
    cyc(10);
    dbg <= 1'b1;
    cyc(3);
    @(negedge clk);
    h = {6'h00, busy, sck};
    cyc(20);
    @(negedge clk);
    cmp("frozen hold", h, {6'h00, busy, sck});
    @(posedge clk);
    dbg <= 1'b0;
    mfinish(w);
    @(posedge clk);
    dbg <= 1'b1;
    brd();
    @(negedge clk);
    cmp("debug read", 8'h01, rbf);
    @(posedge clk);
    dbg <= 1'b0;
    cyc(2);
    @(negedge clk);
    cmp("after debug", 8'h01, rbf);
    brd();
    $display("test debug master done");
    @(posedge clk);
    ms <= 1'b0;
    spe <= 1'b1;
    slp <= 1'b1;
    idl <= 1'b1;
    ids <= 1'b1;
    w = rnd();
    sxfer(w);
    exp_q.push_back(s);
    wait_rbf();
    @(negedge clk);
    cmp("slave rx", exp_q.pop_front(), rdata);
    cmp("slave tx", w, erx);
    cmp("slave event", 8'h01, evt);
    for (k = 0; k < 8; k++) begin
      h = rnd();
      @(posedge clk);
      een <= k[0];
      eprio <= h[2:0];
      cprio <= h[5:3];
      @(negedge clk);
      cmp("wake", {7'h00, k[0] && (h[2:0] > h[5:3])}, {7'h00, wake});
    end
    @(posedge clk);
    slp <= 1'b0;
    idl <= 1'b0;
    cyc(3);
    @(negedge clk);
    cmp("sleep keeps", s, rdata);
    cmp("sleep keeps full", 8'h01, rbf);
    brd();
    @(posedge clk);
    dbg <= 1'b1;
    w = rnd();
    sxfer(w);
    cyc(20);
    @(negedge clk);
    cmp("frozen slave tx", w, erx);
    cmp("frozen slave rx", 8'h00, rbf);
    @(posedge clk);
    dbg <= 1'b0;
    cyc(20);
    @(negedge clk);
    cmp("discarded", 8'h00, rbf);
    $display("test slave done");
    for (k = 0; k < 8; k++) begin
      s = rnd();
      @(posedge clk);
      {en, ms, dod, fme, fsd} <= s[4:0];
      @(negedge clk);
      cmp("pin dirs", {4'h0, s[4], s[4] & s[3], s[4] & ~s[2], s[4] & s[1] & ~s[0]},
        {4'h0, ovr, sck_oe, sdo_oe, ssp_oe});
    end
    $display("test pins done");
    complete_run();
  end
endmodule
